// [shared/mqf_defines.svh]
// Sizes, depth and reset offsets for the almost-flag logic.
`ifndef MQF_DEFINES_SVH
`define MQF_DEFINES_SVH
`define MQF_NUM_Q       4
`define MQF_QW          2
`define MQF_DEVW        3
`define MQF_LVLW        14
`define MQF_DEPTH       14'h2000
`define MQF_AF_OFF_RST  14'h0008
`define MQF_AE_OFF_RST  14'h0008
`endif

// [shared/mqf_pkg.sv]
// Types shared by the almost-flag logic.
package mqf_pkg;
	typedef enum logic [1:0] {
		MQF_RD_RUN,
		MQF_RD_OLD,
		MQF_RD_NEW
	} mqf_rd_state_t;
endpackage

// [rtl/mqf_queue_level.sv]
// Fill level and almost-boundary compare for one queue.
`include "mqf_defines.svh"
module mqf_queue_level (
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	// Configuration
	input  wire logic                 cfg_load_in,
	input  wire logic [`MQF_LVLW-1:0] cfg_af_off_in,
	input  wire logic [`MQF_LVLW-1:0] cfg_ae_off_in,
	// Traffic
	input  wire logic                 wr_in,
	input  wire logic                 rd_in,
	// Status
	output logic                      empty_out,
	output logic                      full_out,
	output logic                      af_now_out,
	output logic                      af_old_out,
	output logic                      ae_now_out,
	output logic                      ae_old_out
);
	logic [`MQF_LVLW-1:0] level_r;
	logic [`MQF_LVLW-1:0] level_nxt;
	logic [`MQF_LVLW-1:0] af_off_r;
	logic [`MQF_LVLW-1:0] af_off_nxt;
	logic [`MQF_LVLW-1:0] ae_off_r;
	logic [`MQF_LVLW-1:0] ae_off_nxt;
	logic                 do_wr;
	logic                 do_rd;

	always_comb begin
		empty_out  = (level_r == '0);
		full_out   = (level_r == `MQF_DEPTH);
		do_wr      = wr_in && !full_out;
		do_rd      = rd_in && !empty_out;
		level_nxt  = level_r;
		if (do_wr && !do_rd) begin
			level_nxt = level_r + 14'h0001;
		end else if (do_rd && !do_wr) begin
			level_nxt = level_r - 14'h0001;
		end
		// RL19 offsets loaded
		af_off_nxt = cfg_load_in ? cfg_af_off_in : af_off_r;
		ae_off_nxt = cfg_load_in ? cfg_ae_off_in : ae_off_r;
		// RL19 level compare
		af_now_out = (level_nxt >= (`MQF_DEPTH - af_off_r));
		af_old_out = (level_r >= (`MQF_DEPTH - af_off_r));
		ae_now_out = (level_nxt <= ae_off_r);
		ae_old_out = (level_r <= ae_off_r);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			level_r  <= '0;
			af_off_r <= `MQF_AF_OFF_RST;
			ae_off_r <= `MQF_AE_OFF_RST;
		end else begin
			level_r  <= level_nxt;
			af_off_r <= af_off_nxt;
			ae_off_r <= ae_off_nxt;
		end
	end
endmodule // mqf_queue_level

// [rtl/mqf_almost_flags.sv]
// Almost-full and almost-empty flag logic of one multi-queue device.
// Behaviour
// RL1 - Almost-full asserts two cycles after write.
// RL2 - Queue switch updates almost-full after two cycles.
// RL3 - Unselected write device floats almost-full.
// RL4 - Read clears almost-full one cycle later.
// RL5 - Almost-empty asserts two cycles after read.
// RL6 - Write clears almost-empty one cycle later.
// RL7 - New read queue status with first word.
// RL8 - Unselected read device floats flag, data.
// RL9 - One more old word after selection.
// RL10 - Write lifts read-side almost-empty after skew.
// RL11 - Empty status bus switches after one cycle.
// RL12 - Bus handover drives new, releases old.
// RL13 - Status bus bit index equals queue.
// RL14 - Full status bus follows selection next cycle.
// RL15 - Read raises full bus bit after skew.
// RL16 - System ties chain inputs for direct mode.
// RL17 - System wires data bits position to position.
// RL18 - Selection fall-through ignores read enable.
// RL19 - Per-queue offsets loaded, compared with level.
`include "mqf_defines.svh"
module mqf_almost_flags (
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	// Identity and clock skew
	input  wire logic [`MQF_DEVW-1:0] dev_id_in,
	input  wire logic                 skew_violated_in,
	// Configuration
	input  wire logic                 cfg_load_in,
	input  wire logic [`MQF_QW-1:0]   cfg_queue_in,
	input  wire logic [`MQF_LVLW-1:0] cfg_af_off_in,
	input  wire logic [`MQF_LVLW-1:0] cfg_ae_off_in,
	// Write port
	input  wire logic                 wr_sel_in,
	input  wire logic [`MQF_DEVW-1:0] wr_sel_dev_in,
	input  wire logic [`MQF_QW-1:0]   wr_sel_queue_in,
	input  wire logic                 wr_en_n_in,
	// Read port
	input  wire logic                 rd_sel_in,
	input  wire logic [`MQF_DEVW-1:0] rd_sel_dev_in,
	input  wire logic [`MQF_QW-1:0]   rd_sel_queue_in,
	input  wire logic                 rd_en_n_in,
	// Status bus selection
	input  wire logic                 afbus_sel_in,
	input  wire logic [`MQF_DEVW-1:0] afbus_sel_dev_in,
	input  wire logic                 aebus_sel_in,
	input  wire logic [`MQF_DEVW-1:0] aebus_sel_dev_in,
	// Read strobe towards queue storage
	output logic                      rd_strobe_out,
	output logic [`MQF_QW-1:0]        rd_queue_out,
	output logic                      data_oe_out,
	// Discrete flags
	output logic                      almost_full_flag_n_out,
	output logic                      almost_full_flag_n_oe_out,
	output logic                      almost_empty_flag_n_out,
	output logic                      almost_empty_flag_n_oe_out,
	// Status buses
	output logic [`MQF_NUM_Q-1:0]     almost_full_status_bus_out,
	output logic                      almost_full_status_bus_oe_out,
	output logic [`MQF_NUM_Q-1:0]     almost_empty_status_bus_out,
	output logic                      almost_empty_status_bus_oe_out
);
	logic [`MQF_NUM_Q-1:0] q_wr;
	logic [`MQF_NUM_Q-1:0] q_rd;
	logic [`MQF_NUM_Q-1:0] q_empty;
	logic [`MQF_NUM_Q-1:0] af_now;
	logic [`MQF_NUM_Q-1:0] af_old;
	logic [`MQF_NUM_Q-1:0] ae_now;
	logic [`MQF_NUM_Q-1:0] ae_old;
	logic [`MQF_NUM_Q-1:0] af_vis;
	logic [`MQF_NUM_Q-1:0] ae_vis;

	logic                  wr_mine_r,  wr_mine_nxt;
	logic [`MQF_QW-1:0]    wr_q_r,     wr_q_nxt;
	logic                  rd_mine_r,  rd_mine_nxt;
	logic [`MQF_QW-1:0]    rd_q_r,     rd_q_nxt;
	logic                  pend_mine_r, pend_mine_nxt;
	logic [`MQF_QW-1:0]    pend_q_r,   pend_q_nxt;
	mqf_pkg::mqf_rd_state_t rd_st_r,   rd_st_nxt;
	logic                  afbus_mine_r, afbus_mine_nxt;
	logic                  aebus_mine_r, aebus_mine_nxt;
	logic                  af_flag_r,  af_flag_nxt;
	logic                  ae_flag_r,  ae_flag_nxt;
	logic [`MQF_NUM_Q-1:0] af_bus_r,   af_bus_nxt;
	logic [`MQF_NUM_Q-1:0] ae_bus_r,   ae_bus_nxt;
	logic                  af_pin_r,   af_pin_nxt;
	logic                  ae_pin_r,   ae_pin_nxt;
	logic [`MQF_NUM_Q-1:0] af_bpin_r,  af_bpin_nxt;
	logic [`MQF_NUM_Q-1:0] ae_bpin_r,  ae_bpin_nxt;
	logic                  rd_go;

	// Flag as seen one edge later: assertion needs two edges, the
	// clearing direction only one unless the skew window is missed.
	function automatic logic late_flag(input logic now_f,
	                                   input logic old_f,
	                                   input logic skew_bad);
		late_flag = skew_bad ? old_f : (now_f && old_f);
	endfunction

	genvar g;
	generate
		for (g = 0; g < `MQF_NUM_Q; g++) begin : g_q
			assign q_wr[g] = wr_mine_r && !wr_en_n_in && (wr_q_r == g);
			assign q_rd[g] = rd_go && (rd_q_r == g);
			// RL4 RL15 full clearing
			assign af_vis[g] = late_flag(af_now[g], af_old[g],
			                             skew_violated_in);
			// RL6 RL10 empty clearing
			assign ae_vis[g] = late_flag(ae_now[g], ae_old[g],
			                             skew_violated_in);
			mqf_queue_level u_lvl (
				.clk_in        (clk_in),
				.rst_n_in      (rst_n_in),
				.cfg_load_in   (cfg_load_in && (cfg_queue_in == g)),
				.cfg_af_off_in (cfg_af_off_in),
				.cfg_ae_off_in (cfg_ae_off_in),
				.wr_in         (q_wr[g]),
				.rd_in         (q_rd[g]),
				.empty_out     (q_empty[g]),
				.full_out      (),
				.af_now_out    (af_now[g]),
				.af_old_out    (af_old[g]),
				.ae_now_out    (ae_now[g]),
				.ae_old_out    (ae_old[g])
			);
		end
	endgenerate

	// RL18 forced fall-through reads
	assign rd_go = rd_mine_r && !q_empty[rd_q_r] &&
	               (!rd_en_n_in || (rd_st_r != mqf_pkg::MQF_RD_RUN));

	always_comb begin
		wr_mine_nxt    = wr_mine_r;
		wr_q_nxt       = wr_q_r;
		rd_mine_nxt    = rd_mine_r;
		rd_q_nxt       = rd_q_r;
		pend_mine_nxt  = pend_mine_r;
		pend_q_nxt     = pend_q_r;
		rd_st_nxt      = rd_st_r;
		afbus_mine_nxt = afbus_mine_r;
		aebus_mine_nxt = aebus_mine_r;
		if (wr_sel_in) begin
			wr_mine_nxt = (wr_sel_dev_in == dev_id_in);
			wr_q_nxt    = wr_sel_queue_in;
		end
		unique case (rd_st_r)
			mqf_pkg::MQF_RD_RUN: begin
			end
			// RL9 last old word
			mqf_pkg::MQF_RD_OLD: begin
				rd_st_nxt   = mqf_pkg::MQF_RD_NEW;
				rd_mine_nxt = pend_mine_r;
				rd_q_nxt    = pend_q_r;
			end
			mqf_pkg::MQF_RD_NEW: begin
				rd_st_nxt = mqf_pkg::MQF_RD_RUN;
			end
		endcase
		if (rd_sel_in) begin
			pend_mine_nxt = (rd_sel_dev_in == dev_id_in);
			pend_q_nxt    = rd_sel_queue_in;
			rd_st_nxt     = mqf_pkg::MQF_RD_OLD;
		end
		// RL11 RL12 RL14 bus ownership
		if (afbus_sel_in) begin
			afbus_mine_nxt = (afbus_sel_dev_in == dev_id_in);
		end
		if (aebus_sel_in) begin
			aebus_mine_nxt = (aebus_sel_dev_in == dev_id_in);
		end
		// RL1 RL2 discrete full flag
		af_flag_nxt = af_vis[wr_q_r];
		// RL5 RL7 discrete empty flag
		ae_flag_nxt = ae_vis[rd_q_nxt];
		// RL13 bit per queue
		af_bus_nxt  = af_vis;
		ae_bus_nxt  = ae_vis;
		// RL1 RL5 second flag stage
		af_pin_nxt  = af_flag_r;
		ae_pin_nxt  = ae_flag_r;
		af_bpin_nxt = af_bus_r;
		ae_bpin_nxt = ae_bus_r;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_mine_r    <= 1'b0;
			wr_q_r       <= '0;
			rd_mine_r    <= 1'b0;
			rd_q_r       <= '0;
			pend_mine_r  <= 1'b0;
			pend_q_r     <= '0;
			rd_st_r      <= mqf_pkg::MQF_RD_RUN;
			afbus_mine_r <= 1'b0;
			aebus_mine_r <= 1'b0;
			af_flag_r    <= 1'b0;
			ae_flag_r    <= 1'b1;
			af_bus_r     <= '0;
			ae_bus_r     <= '1;
			af_pin_r     <= 1'b0;
			ae_pin_r     <= 1'b1;
			af_bpin_r    <= '0;
			ae_bpin_r    <= '1;
		end else begin
			wr_mine_r    <= wr_mine_nxt;
			wr_q_r       <= wr_q_nxt;
			rd_mine_r    <= rd_mine_nxt;
			rd_q_r       <= rd_q_nxt;
			pend_mine_r  <= pend_mine_nxt;
			pend_q_r     <= pend_q_nxt;
			rd_st_r      <= rd_st_nxt;
			afbus_mine_r <= afbus_mine_nxt;
			aebus_mine_r <= aebus_mine_nxt;
			af_flag_r    <= af_flag_nxt;
			ae_flag_r    <= ae_flag_nxt;
			af_bus_r     <= af_bus_nxt;
			ae_bus_r     <= ae_bus_nxt;
			af_pin_r     <= af_pin_nxt;
			ae_pin_r     <= ae_pin_nxt;
			af_bpin_r    <= af_bpin_nxt;
			ae_bpin_r    <= ae_bpin_nxt;
		end
	end

	// The flags are registered so a queue switch and an asserting boundary
	// crossing show up with the same two-edge latency.
	assign rd_strobe_out                  = rd_go;
	assign rd_queue_out                   = rd_q_r;
	// RL8 data float
	assign data_oe_out                    = rd_mine_r;
	// RL3 full flag float
	assign almost_full_flag_n_oe_out      = wr_mine_r;
	assign almost_full_flag_n_out         = !af_pin_r;
	// RL8 empty flag float
	assign almost_empty_flag_n_oe_out     = rd_mine_r;
	assign almost_empty_flag_n_out        = !ae_pin_r;
	// RL12 bus drive
	assign almost_full_status_bus_oe_out  = afbus_mine_r;
	assign almost_full_status_bus_out     = ~af_bpin_r;
	assign almost_empty_status_bus_oe_out = aebus_mine_r;
	assign almost_empty_status_bus_out    = ~ae_bpin_r;
endmodule // mqf_almost_flags

// [test/mqf_host_model.sv]
// Host model that selects queues and moves words through the device.
// chain pins and data wiring stay outside this model.
module mqf_host_model (
	// Clock
	input wire logic    clk_in,
	// Requests towards the device
	output logic        cfg_load_out, wsel_out, rsel_out, fsel_out,
	output logic        esel_out, wen_n_out, ren_n_out,
	output logic [1:0]  cfg_q_out, q_out,
	output logic [2:0]  dev_out,
	output logic [13:0] af_out, ae_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{cfg_load_out, wsel_out, rsel_out, fsel_out, esel_out} = '0;
		{cfg_q_out, q_out, dev_out, af_out, ae_out} = '0;
		{wen_n_out, ren_n_out} = 2'h3;
	end
	task automatic cfg(input logic [1:0] q, input logic [13:0] af, ae);
		@(posedge clk_in);
		{cfg_load_out, cfg_q_out, af_out, ae_out} <= {1'b1, q, af, ae};
		@(posedge clk_in);
		cfg_load_out <= 1'b0;
	endtask
	// Kinds: 0 write port, 1 read port, 2 and 3 the status buses.
	task automatic sel(input int k, input logic [2:0] d, input logic [1:0] q);
		@(posedge clk_in);
		{wsel_out, rsel_out, fsel_out, esel_out} <= 4'h8 >> k;
		{dev_out, q_out} <= {d, q};
		@(posedge clk_in);
		{wsel_out, rsel_out, fsel_out, esel_out} <= '0;
		// Stale qualifiers toggle, so nothing may lean on them.
		{dev_out, q_out} <= ~{d, q};
	endtask
	task automatic move(input logic w, input int n);
		@(posedge clk_in);
		wen_n_out <= !w;
		ren_n_out <= w;
		repeat (n) @(posedge clk_in);
		{wen_n_out, ren_n_out} <= 2'h3;
	endtask
endmodule // mqf_host_model

// [test/mqf_almost_flags_properties.sv]
// Port-level checks of the almost-flag logic.
module mqf_almost_flags_properties (
	// Clock, reset and selections
	input wire logic       clk_in, rst_n_in, wr_sel_in, rd_sel_in,
	input wire logic       afbus_sel_in, aebus_sel_in,
	input wire logic [2:0] dev_id_in, wr_sel_dev_in, rd_sel_dev_in,
	input wire logic [2:0] afbus_sel_dev_in, aebus_sel_dev_in,
	input wire logic [1:0] rd_sel_queue_in, rd_queue_out,
	// Enables under watch
	input wire logic       data_oe_out, almost_full_flag_n_oe_out,
	input wire logic       almost_empty_flag_n_oe_out,
	input wire logic       almost_full_status_bus_oe_out,
	input wire logic       almost_empty_status_bus_oe_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire own_w = wr_sel_dev_in == dev_id_in;
	wire own_r = rd_sel_dev_in == dev_id_in;
	property p_af_on; wr_sel_in && own_w |=> almost_full_flag_n_oe_out;
	endproperty
	a_af_on: assert property (p_af_on) else $error("af oe late");
	property p_af_off; wr_sel_in && !own_w |=> !almost_full_flag_n_oe_out;
	endproperty
	a_af_off: assert property (p_af_off) else $error("af oe kept");
	property p_af_keep;
		almost_full_flag_n_oe_out && !wr_sel_in |=> almost_full_flag_n_oe_out;
	endproperty
	a_af_keep: assert property (p_af_keep) else $error("af oe lost");
	property p_fbus; afbus_sel_in |=>
		almost_full_status_bus_oe_out == ($past(afbus_sel_dev_in) == dev_id_in);
	endproperty
	a_fbus: assert property (p_fbus) else $error("af bus owner");
	property p_ebus; aebus_sel_in |=>
		almost_empty_status_bus_oe_out == ($past(aebus_sel_dev_in) == dev_id_in);
	endproperty
	a_ebus: assert property (p_ebus) else $error("ae bus owner");
	property p_ekeep;
		!aebus_sel_in |=> $stable(almost_empty_status_bus_oe_out);
	endproperty
	a_ekeep: assert property (p_ekeep) else $error("ae bus oe moved");
	property p_rd_own; rd_sel_in && own_r ##1 !rd_sel_in |=> data_oe_out &&
		almost_empty_flag_n_oe_out && rd_queue_out == $past(rd_sel_queue_in, 2);
	endproperty
	a_rd_own: assert property (p_rd_own) else $error("read switch");
	property p_rd_other; rd_sel_in && !own_r ##1 !rd_sel_in |=>
		!data_oe_out && !almost_empty_flag_n_oe_out;
	endproperty
	a_rd_other: assert property (p_rd_other) else $error("read float");
	c_wr: cover property (wr_sel_in && own_w);
	c_rd: cover property (rd_sel_in && own_r);
	c_bus: cover property (aebus_sel_in ##1 almost_empty_status_bus_oe_out);
endmodule // mqf_almost_flags_properties
bind mqf_almost_flags mqf_almost_flags_properties chk_u (.*);

// [test/mqf_almost_flags_tb.sv]
// Self-checking bench for the almost-flag logic.
module mqf_almost_flags_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in = 1'b0, rst_n_in = 1'b0, skew_violated_in = 1'b0;
	logic [2:0]  dev_id_in = 3'h1, dv;
	logic [1:0]  qn, cfg_queue_in, rd_queue_out;
	logic [13:0] cfg_af_off_in, cfg_ae_off_in;
	logic        cfg_load_in, wr_sel_in, rd_sel_in, afbus_sel_in;
	logic        aebus_sel_in, wr_en_n_in, rd_en_n_in, rd_strobe_out;
	logic        data_oe_out, almost_full_flag_n_oe_out, af, ae;
	logic        almost_empty_flag_n_oe_out, almost_full_status_bus_oe_out;
	logic        almost_empty_status_bus_oe_out;
	logic [3:0]  almost_full_status_bus_out, almost_empty_status_bus_out;
	int          fail_count = 0, comparisons = 0;
	always #4 clk_in = ~clk_in;
	mqf_host_model host_u (.clk_in(clk_in), .cfg_load_out(cfg_load_in),
		.wsel_out(wr_sel_in), .rsel_out(rd_sel_in), .fsel_out(afbus_sel_in),
		.esel_out(aebus_sel_in), .wen_n_out(wr_en_n_in),
		.ren_n_out(rd_en_n_in), .cfg_q_out(cfg_queue_in), .q_out(qn),
		.dev_out(dv), .af_out(cfg_af_off_in), .ae_out(cfg_ae_off_in));
	mqf_almost_flags dut_u (.wr_sel_dev_in(dv), .rd_sel_dev_in(dv),
		.afbus_sel_dev_in(dv), .aebus_sel_dev_in(dv),
		.wr_sel_queue_in(qn), .rd_sel_queue_in(qn),
		.almost_full_flag_n_out(af), .almost_empty_flag_n_out(ae), .*);
	task automatic chk(input logic [3:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Queue 2 turns almost full at two words and is almost empty only while empty.
	task automatic s_write();
		host_u.cfg(2'h2, 14'h1FFE, 14'h0000);
		tick(0);
		chk(almost_full_flag_n_oe_out, 0);
		host_u.sel(0, 3'h1, 2'h2);
		tick(1);
		chk(almost_full_flag_n_oe_out, 1);
		tick(1);
		chk(af, 1);
		host_u.move(1, 2);
		tick(1);
		chk(af, 1);
		tick(1);
		chk(af, 0);
		host_u.sel(0, 3'h1, 2'h0);
		tick(1);
		chk(af, 0);
		tick(1);
		chk(af, 1);
		host_u.sel(0, 3'h1, 2'h2);
	endtask
	task automatic s_read();
		host_u.sel(1, 3'h3, 2'h1);
		tick(2);
		chk({data_oe_out, almost_empty_flag_n_oe_out}, 0);
		host_u.sel(1, 3'h1, 2'h2);
		tick(0);
		chk(data_oe_out, 0);
		tick(1);
		chk({data_oe_out, rd_strobe_out, rd_queue_out}, 4'hE);
		tick(1);
		chk({ae, af}, 4'h2);
		tick(1);
		chk(af, 1);
	endtask
	task automatic s_skew();
		host_u.move(0, 1);
		tick(1);
		chk(ae, 1);
		tick(1);
		chk(ae, 0);
		@(posedge clk_in);
		skew_violated_in <= 1'b1;
		host_u.move(1, 1);
		tick(1);
		chk(ae, 0);
		tick(1);
		chk(ae, 1);
		@(posedge clk_in);
		skew_violated_in <= 1'b0;
	endtask
	task automatic s_bus();
		host_u.sel(2, 3'h1, 2'h0);
		tick(1);
		chk(almost_full_status_bus_out, 4'hF);
		host_u.sel(3, 3'h1, 2'h0);
		tick(1);
		chk(almost_empty_status_bus_out, 4'h4);
		host_u.sel(3, 3'h5, 2'h0);
		tick(1);
		chk(almost_empty_status_bus_oe_out, 0);
		host_u.sel(0, 3'h4, 2'h0);
		tick(1);
		chk(almost_full_flag_n_oe_out, 0);
		// The last word of queue 2 leaves before empty queue 0 takes over.
		host_u.sel(1, 3'h1, 2'h0);
		tick(0);
		chk({data_oe_out, rd_strobe_out, rd_queue_out}, 4'hE);
		tick(1);
		chk({data_oe_out, rd_strobe_out, rd_queue_out}, 4'h8);
	endtask
	initial begin
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		s_write();
		s_read();
		s_skew();
		s_bus();
		print_verdict();
	end
	initial begin
		repeat (5000) @(posedge clk_in);
		fail_count++;
		print_verdict();
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
endmodule // mqf_almost_flags_tb
